// file: gci_codec_pkg.sv
/*
 * Constants, types and companding functions shared by the GCI PCM port.
 * Assumes 14-bit two's complement linear samples on the user side.
 */
package gci_codec_pkg;

   localparam int          LIN_W          = 14;
   localparam int          CODE_W         = 8;
   localparam int          FIFO_DEPTH     = 16;
   // Data-clock rising edges counted from the frame start.
   localparam logic [4:0]  SLOT_B1_BASE   = 5'h00;
   localparam logic [4:0]  SLOT_B2_BASE   = 5'h10;
   localparam logic [4:0]  WORD_LAST_RISE = 5'h0F;
   localparam logic [4:0]  CNT_MAX        = 5'h1F;
   localparam logic [13:0] STEP_BIAS      = 14'h0021;
   localparam logic [13:0] MU_MAG_MAX     = 14'h1FDE;
   localparam logic [13:0] A_MAG_MAX      = 14'h0FFF;
   localparam logic [7:0]  MU_INV         = 8'h7F;
   localparam logic [7:0]  A_INV          = 8'h55;
   localparam logic [7:0]  MU_SILENCE     = 8'hFF;
   localparam logic [7:0]  A_SILENCE      = 8'hD5;
   localparam int          MU_CHORD_BASE  = 6;
   localparam int          A_CHORD_BASE   = 5;

   typedef enum logic { LAW_MU, LAW_A } law_e;
   typedef enum logic { PH_IDLE, PH_FRAME } phase_e;
   typedef struct packed {
      logic dcl;
      logic fsc;
      logic din;
   } link_s;
   typedef logic signed [13:0] lin_t;

   // Chord is one more than the offset of the highest set bit from the base, or 0 if no bit from the base up is set.
   function automatic logic [2:0] chord_of(input logic [12:0] v,
                                           input int base);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (v[base + i]) begin
            c = 3'(i + 1);
         end
      end
      return c;
   endfunction : chord_of

   function automatic logic [13:0] magnitude(input lin_t s,
                                             input logic [13:0] lim);
      logic [13:0] m;
      m = s[13] ? 14'(-s) : 14'(s);
      return (m > lim) ? lim : m;
   endfunction : magnitude

   function automatic logic [7:0] mu_encode(input lin_t s);
      logic [12:0] b;
      logic [2:0]  c;
      logic [12:0] sh;
      b  = 13'(magnitude(s, MU_MAG_MAX) + STEP_BIAS);
      c  = chord_of(b, MU_CHORD_BASE);
      sh = b >> ({1'b0, c} + 4'h1);
      return {~s[13], c, sh[3:0]} ^ MU_INV;
   endfunction : mu_encode

   function automatic logic [7:0] a_encode(input lin_t s);
      logic [12:0] m;
      logic [2:0]  c;
      logic [12:0] sh;
      m  = 13'(magnitude(s, A_MAG_MAX));
      c  = chord_of(m, A_CHORD_BASE);
      sh = (c == 3'h0) ? (m >> 1) : (m >> c);
      return {~s[13], c, sh[3:0]} ^ A_INV;
   endfunction : a_encode

   // Expansion returns the middle of the step that the code names.
   function automatic lin_t mu_expand(input logic [7:0] code);
      logic [7:0]  x;
      logic [13:0] t;
      logic [13:0] v;
      x = code ^ MU_INV;
      t = 14'({x[3:0], 1'b0}) + STEP_BIAS;
      v = 14'(t << x[6:4]) - STEP_BIAS;
      return x[7] ? lin_t'(v) : lin_t'(-v);
   endfunction : mu_expand

   function automatic lin_t a_expand(input logic [7:0] code);
      logic [7:0]  x;
      logic [13:0] t;
      logic [13:0] v;
      x = code ^ A_INV;
      t = 14'({x[3:0], 1'b0}) + STEP_BIAS;
      if (x[6:4] == 3'h0) begin
         v = 14'({x[3:0], 1'b1});
      end else begin
         v = 14'(t << (x[6:4] - 3'h1));
      end
      return x[7] ? lin_t'(v) : lin_t'(-v);
   endfunction : a_expand

endpackage : gci_codec_pkg

// file: gci_far_end.sv
/*
 * Behavioural GCI controller that faces the companding port's link pins.
 * Assumes a 800 ns data clock that stands still between frames.
 */
module gci_far_end
   import gci_codec_pkg::*;
(
   // Link pins towards the port.
   output link_s       link_o,
   input  wire logic   dout_i,
   input  wire logic   dout_oe_n_i,
   // Word captured in the last frame.
   output logic [7:0]  got_code_o,
   output logic        got_oe_ok_o,
   output logic        got_stb_o
);
   timeunit 1ns;
   timeprecision 1ns;

   localparam int HALF     = 400;
   localparam int FRAME_NS = 125000;

   initial begin
      link_o      = '0;
      got_code_o  = 8'h00;
      got_oe_ok_o = 1'b0;
      got_stb_o   = 1'b0;
   end

   task automatic frame(input logic [7:0] rx_code, input logic b2,
                        input logic fsc_last);
      time         t0;
      int          o;
      int          j;
      logic [7:0]  w;
      logic        ok;
      t0 = $time;
      o  = b2 ? 16 : 0;
      w  = 8'h00;
      ok = 1'b1;
      if (fsc_last) begin
         link_o.dcl = 1'b1;
         #(HALF / 2);
         link_o.fsc = 1'b1;
      end else begin
         link_o.fsc = 1'b1;
         #(HALF / 2);
         link_o.dcl = 1'b1;
      end
      for (int k = 0; k < 32; k++) begin
         #(HALF / 2);
         // FSC moves mid-high, so it is steady around every fall.
         if (k == 1) link_o.fsc = 1'b0;
         #(HALF / 2);
         j = k - o;
         if (j >= 1 && j <= 15 && j % 2 == 1) begin
            w[7 - (j - 1) / 2] = dout_i;
            ok &= (dout_oe_n_i === 1'b0);
         end
         if (j < 0 || j > 16) ok &= (dout_oe_n_i === 1'b1);
         link_o.dcl = 1'b0;
         j = k + 1 - o;
         // Outside our slot DIN toggles, so a stray sample is caught.
         if (j >= 1 && j <= 15 && j % 2 == 1) begin
            link_o.din = rx_code[7 - (j - 1) / 2];
         end else begin
            link_o.din = ~link_o.din;
         end
         #(HALF);
         if (k < 31) link_o.dcl = 1'b1;
      end
      #(HALF);
      ok &= (dout_oe_n_i === 1'b1);
      got_code_o  = w;
      got_oe_ok_o = ok;
      got_stb_o   = 1'b1;
      #1;
      got_stb_o   = 1'b0;
      #(FRAME_NS - ($time - t0));
   endtask : frame
endmodule : gci_far_end

// file: gci_pcm_companding_port.sv
/*
 * Transmit sample FIFO and the GCI PCM companding port.
 * Assumes DCL and FSC come from a far controller, are slow against
 * CORE_CLK_I and are sampled through two flip-flops here.
 */
module sample_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             ce_i,
   input  wire logic             rst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   wire              push = in_valid_i & in_ready_o & ce_i;
   wire              pop  = out_valid_o & out_ready_i & ce_i;

   assign in_ready_o  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
   assign out_valid_o = wr_q != rd_q;
   assign out_data_o  = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end
endmodule : sample_fifo

module gci_pcm_companding_port
   import gci_codec_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic              CORE_CLK_I,
   input  wire logic              RST_N_I,
   input  wire logic              CE_I,
   // Static configuration.
   input  wire law_e              LAW_SEL_I,
   input  wire logic              SLOT_B2_I,
   // GCI link pins.
   input  wire logic              DCL_I,
   input  wire logic              FSC_I,
   input  wire logic              DIN_I,
   output logic                   DOUT_O,
   output logic                   DOUT_OE_N_O,
   // Transmit samples.
   input  wire logic [LIN_W-1:0]  TX_SAMPLE_I,
   input  wire logic              TX_VALID_I,
   output logic                   TX_READY_O,
   // Received samples.
   output logic [LIN_W-1:0]       RX_SAMPLE_O,
   output logic                   RX_VALID_O
);

   link_s             sync1_q;
   link_s             sync2_q;
   link_s             prev_q;
   phase_e            phase_q;
   logic [4:0]        cnt_q;
   logic [4:0]        drv_rises_q;
   logic [7:0]        word_q;
   logic [6:0]        rx_sh_q;
   logic              dout_q;
   logic              oe_q;
   logic [LIN_W-1:0]  rx_q;
   logic              rx_valid_q;
   logic              fifo_valid;
   logic [LIN_W-1:0]  fifo_data;

   wire link_s pins = '{dcl: DCL_I, fsc: FSC_I, din: DIN_I};

   // The first stage feeds only the second stage.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else if (CE_I) begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   wire dcl_rise = sync2_q.dcl & ~prev_q.dcl;
   wire dcl_fall = ~sync2_q.dcl & prev_q.dcl;
   wire fsc_rise = sync2_q.fsc & ~prev_q.fsc;
   wire start    = (phase_q == PH_IDLE) &
                   ((fsc_rise & sync2_q.dcl) |
                    (dcl_rise & sync2_q.fsc));

   wire [4:0] base    = SLOT_B2_I ? SLOT_B2_BASE : SLOT_B1_BASE;
   wire       advance = dcl_rise & (cnt_q != CNT_MAX);
   wire [4:0] cnt_d   = start ? 5'h00 : (advance ? cnt_q + 5'h01 : cnt_q);
   wire [4:0] rel_d   = cnt_d - base;
   wire       slot_d  = (cnt_d >= base) & (rel_d <= WORD_LAST_RISE);
   // A stray rise after the count has saturated must not touch the slot.
   wire       bit_ev  = (start | advance) & slot_d;
   wire [2:0] bit_idx = 3'h7 - rel_d[3:1];

   wire       is_a    = LAW_SEL_I == LAW_A;
   wire [7:0] enc     = is_a ? a_encode(lin_t'(fifo_data))
                             : mu_encode(lin_t'(fifo_data));
   wire [7:0] idle    = is_a ? A_SILENCE : MU_SILENCE;
   wire [7:0] word_d  = start ? (fifo_valid ? enc : idle) : word_q;
   wire [7:0] rx_code = {rx_sh_q, sync2_q.din};
   wire lin_t rx_lin  = is_a ? a_expand(rx_code)
                             : mu_expand(rx_code);
   wire       rx_take = advance & slot_d & rel_d[0];
   wire       rx_done = rx_take & (rel_d == WORD_LAST_RISE);
   wire       release_ev = dcl_fall & oe_q &
                           (cnt_q == base + WORD_LAST_RISE);

   sample_fifo #(
      .WIDTH (LIN_W),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i       (CORE_CLK_I),
      .ce_i        (CE_I),
      .rst_n_i     (RST_N_I),
      .in_valid_i  (TX_VALID_I),
      .in_ready_o  (TX_READY_O),
      .in_data_i   (TX_SAMPLE_I),
      .out_valid_o (fifo_valid),
      .out_ready_i (start),
      .out_data_o  (fifo_data)
   );

   // A frame ends once a falling edge finds the frame sync low.
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         phase_q <= PH_IDLE;
      end else if (CE_I) begin
         if (start) begin
            phase_q <= PH_FRAME;
         end else if (dcl_fall & ~sync2_q.fsc) begin
            phase_q <= PH_IDLE;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         cnt_q  <= CNT_MAX;
         word_q <= MU_SILENCE;
      end else if (CE_I) begin
         cnt_q  <= cnt_d;
         word_q <= word_d;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         dout_q <= 1'b0;
         oe_q   <= 1'b0;
      end else if (CE_I) begin
         if (bit_ev) begin
            dout_q <= word_d[bit_idx];
            oe_q   <= 1'b1;
         end else if (release_ev) begin
            oe_q   <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         drv_rises_q <= 5'h00;
      end else if (CE_I) begin
         if (!oe_q) begin
            drv_rises_q <= 5'h00;
         end else if (dcl_rise) begin
            drv_rises_q <= drv_rises_q + 5'h01;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         rx_sh_q    <= '0;
         rx_q       <= '0;
         rx_valid_q <= 1'b0;
      end else if (CE_I) begin
         if (rx_take) begin
            rx_sh_q <= rx_code[6:0];
         end
         if (rx_done) begin
            rx_q <= rx_lin;
         end
         rx_valid_q <= rx_done;
      end
   end

   assign DOUT_O      = dout_q;
   assign DOUT_OE_N_O = ~oe_q;
   assign RX_SAMPLE_O = rx_q;
   assign RX_VALID_O  = rx_valid_q;

   a_first_bit_start: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (CE_I && start && !SLOT_B2_I) |=>
         (!DOUT_OE_N_O && DOUT_O == word_q[7]))
      else $error("first bit not driven at frame start");

   a_bit_on_rise: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (!DOUT_OE_N_O && $changed(DOUT_O)) |-> $past(dcl_rise | start))
      else $error("output bit changed without a rising edge");

   a_drive_on_edge: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      $fell(DOUT_OE_N_O) |-> $past(start | advance))
      else $error("output driven outside a counted frame edge");

   a_release_fall: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      $rose(DOUT_OE_N_O) |-> ($past(dcl_fall) &&
                              drv_rises_q == WORD_LAST_RISE))
      else $error("output released at the wrong edge");

   a_frame_fsc_fall: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      ($past(phase_q) == PH_FRAME && phase_q == PH_IDLE) |->
         $past(dcl_fall && !sync2_q.fsc))
      else $error("frame ended without a falling-edge sample");

   a_rx_on_rise: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      RX_VALID_O |-> ($past(dcl_rise) ##1 !RX_VALID_O))
      else $error("receive word not taken on a rising edge");

   a_mu_idle_code: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (CE_I && start && !fifo_valid && LAW_SEL_I == LAW_MU) |=>
         word_q == MU_SILENCE)
      else $error("mu-law zero code is not all ones");

   a_a_idle_code: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (CE_I && start && !fifo_valid && LAW_SEL_I == LAW_A) |=>
         word_q == A_SILENCE)
      else $error("A-law zero code lacks even-bit inversion");

   a_sign_positive: assert property (
      @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (CE_I && start && fifo_valid) |=>
         word_q[7] == !$past(fifo_data[LIN_W-1]))
      else $error("sign bit does not follow sample sign");

endmodule : gci_pcm_companding_port

// file: tb_top.sv
/*
 * Self-checking bench for the GCI PCM companding port.
 * Assumes the far-end model gci_far_end and the shared codec package.
 */
module tb_top import gci_codec_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clk = 1'b0;
   logic              rst_n, slot_b2, tx_valid, tx_ready, rx_valid;
   logic              dout, dout_oe_n, got_oe_ok, got_stb;
   law_e              law;
   link_s             link;
   lin_t              tx_sample;
   logic [LIN_W-1:0]  rx_sample;
   logic [7:0]        got_code, acc;
   logic [7:0]        txq[$];
   lin_t              rxq[$];
   int                miscompares = 0;
   int                check_count = 0;
   int                seed = 32'hB627;
   int                r;

   localparam lin_t SAMP [2][6] = '{
      '{14'sh0000, 14'sh1F5F, -14'sh1F5F, 14'sh1FFF, 14'sh0002, -14'sh0021},
      '{14'sh0000, 14'sh0FC0, -14'sh0FC0, 14'sh1388, 14'sh0042, 14'sh0420}};
   localparam logic [7:0] CODE [2][6] = '{
      '{8'hFF, 8'h80, 8'h00, 8'h80, 8'hFE, 8'h6F},
      '{8'hD5, 8'hAA, 8'h2A, 8'hAA, 8'hF5, 8'hB5}};
   localparam lin_t DEC [2][6] = '{
      '{14'sh0000, 14'sh1F5F, -14'sh1F5F, 14'sh1F5F, 14'sh0002, -14'sh0021},
      '{14'sh0001, 14'sh0FC0, -14'sh0FC0, 14'sh0FC0, 14'sh0042, 14'sh0420}};

   always #50 clk = ~clk;

   gci_pcm_companding_port uut (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .LAW_SEL_I(law),
      .SLOT_B2_I(slot_b2), .DCL_I(link.dcl), .FSC_I(link.fsc),
      .DIN_I(link.din), .DOUT_O(dout), .DOUT_OE_N_O(dout_oe_n),
      .TX_SAMPLE_I(tx_sample), .TX_VALID_I(tx_valid),
      .TX_READY_O(tx_ready), .RX_SAMPLE_O(rx_sample),
      .RX_VALID_O(rx_valid));

   gci_far_end far_end (
      .link_o(link), .dout_i(dout), .dout_oe_n_i(dout_oe_n),
      .got_code_o(got_code), .got_oe_ok_o(got_oe_ok),
      .got_stb_o(got_stb));

   task automatic cmp_code(input string name, input logic [7:0] exp,
                           input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp_code

   task automatic cmp_lin(input string name, input lin_t exp,
                          input logic [LIN_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp_lin

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude

   // Pushes one table sample and notes its code if the FIFO takes it.
   task automatic push(input int p, input int i);
      @(posedge clk);
      tx_sample <= SAMP[p][i];
      tx_valid  <= 1'b1;
      @(negedge clk);
      if (tx_ready === 1'b1) begin
         txq.push_back(CODE[p][i]);
         acc++;
      end
   endtask : push

   always @(posedge got_stb) begin
      if (txq.size() == 0) begin
         cmp_code("tx_unexpected", 8'h00, 8'h01);
      end else begin
         cmp_code("tx_word", txq.pop_front(),
                  got_code);
      end
      cmp_code("tx_release", 8'h01, {7'h00, got_oe_ok});
   end

   always @(negedge clk) begin
      if (rx_valid === 1'b1) begin
         if (rxq.size() == 0) begin
            cmp_code("rx_unexpected", 8'h00, 8'h01);
         end else begin
            cmp_lin("rx_sample", rxq.pop_front(),
                    rx_sample);
         end
      end
   end

   initial begin
      #6_000_000;
      miscompares++;
      conclude();
   end

   initial begin
      rst_n     = 1'b0;
      law       = LAW_MU;
      slot_b2   = 1'b0;
      tx_sample = '0;
      tx_valid  = 1'b0;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         rst_n   <= 1'b0;
         law     <= law_e'(p == 1);
         slot_b2 <= (p == 1);
         repeat (16) @(posedge clk);
         rst_n   <= 1'b1;
         @(negedge clk);
         cmp_code("reset_oe_n", 8'h01, {7'h00, dout_oe_n});
         acc = 8'h00;
         for (int n = 0; n < 17; n++) begin
            push(p, $unsigned($random(seed)) % 6);
         end
         cmp_code("fifo_full", 8'h00, {7'h00, tx_ready});
         cmp_code("fifo_depth", 8'(FIFO_DEPTH), acc);
         @(posedge clk);
         tx_valid <= 1'b0;
         #37;
         for (int f = 0; f < 17; f++) begin
            r = $unsigned($random(seed)) % 6;
            rxq.push_back(DEC[p][r]);
            if (f == 16) txq.push_back((p == 1) ? A_SILENCE : MU_SILENCE);
            far_end.frame(CODE[p][r], p == 1, f % 2 == 1);
         end
      end
      repeat (20) @(posedge clk);
      cmp_code("pending", 8'h00, 8'(txq.size() + rxq.size()));
      conclude();
   end
endmodule : tb_top
